//--- verilog/fusa_pkg.sv
// Package of constants for the flow unit status aggregator
package fusa_pkg;

    // ----------------------------------------
    // Register indices (word addressed)
    // ----------------------------------------
    localparam logic [3:0] ERROR_STATUS_WORD_IDX = 4'h3;
    localparam logic [3:0] ALARM_STATUS_WORD_IDX = 4'h4;
    localparam logic [3:0] WARNING_STATUS_WORD_IDX = 4'h5;
    localparam logic [3:0] UNIT_STATE_WORD_IDX = 4'h6;
    localparam logic [3:0] ALARM_ENABLE_BITS_IDX = 4'h8;
    localparam logic [3:0] WARNING_ENABLE_BITS_IDX = 4'h9;

    // ----------------------------------------
    // Implemented bit positions per word
    // ----------------------------------------
    localparam logic [31:0] ERROR_USED_MASK = 32'h0084_0004;
    localparam logic [31:0] ALARM_USED_MASK = 32'h0180_800f;
    localparam logic [31:0] WARNING_USED_MASK = 32'h0f0e_6f3b;
    localparam logic [31:0] STATE_USED_MASK = 32'h0000_073f;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int WARN_HIGH_TEMP_BIT = 24;
    localparam int WARN_LOW_TEMP_BIT = 25;
    localparam int ST_EXEC_BIT = 0;
    localparam int ST_ANY_ERROR_BIT = 8;
    localparam int ST_ANY_ALARM_BIT = 9;
    localparam int ST_ANY_WARNING_BIT = 10;

    // ----------------------------------------
    // Reset values and timing
    // ----------------------------------------
    localparam logic [31:0] ALARM_ENABLE_RESET = 32'hffff_ffff;
    localparam logic [31:0] WARNING_ENABLE_RESET = 32'hffff_ffff;
    localparam int CLOCK_HZ = 40_000_000;
    localparam int MS_CYCLES = CLOCK_HZ / 1000;

    typedef enum logic [1:0] {
        FUSA_RUN = 2'b00,
        FUSA_SAFE = 2'b01
    } fusa_mode_e;

    typedef enum logic [1:0] {
        FUSA_T_NORMAL = 2'b00,
        FUSA_T_PEND_SET = 2'b01,
        FUSA_T_TRIPPED = 2'b11,
        FUSA_T_PEND_CLR = 2'b10
    } fusa_temp_e;

endpackage : fusa_pkg

//--- verilog/fusa_top.sv
// Status aggregator with masks, safe state and temperature warnings
`timescale 1ns/1ps

module fusa_top
    import fusa_pkg::*;
#(
    parameter int TEMP_WIDTH = 16,
    parameter int SETTLE_MS_WIDTH = 16
)(
    input wire logic clock,
    input wire logic resetn,
    input wire logic [3:0] reg_index,
    input wire logic reg_write,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    input wire logic [31:0] error_sources,
    input wire logic [31:0] alarm_sources,
    input wire logic [31:0] warning_sources,
    input wire logic [5:1] state_sources,
    input wire logic class1_connected,
    input wire logic signed [TEMP_WIDTH-1:0] temperature,
    input wire logic signed [TEMP_WIDTH-1:0] temp_high_trip,
    input wire logic signed [TEMP_WIDTH-1:0] temp_low_trip,
    input wire logic [SETTLE_MS_WIDTH-1:0] temp_settle_ms,
    output logic safe_state,
    output logic [31:0] cyclic_error_word,
    output logic [31:0] cyclic_alarm_word,
    output logic [31:0] cyclic_warning_word,
    output logic [31:0] cyclic_state_word
);

    if (TEMP_WIDTH < 2 || TEMP_WIDTH > 32 || SETTLE_MS_WIDTH < 1 || SETTLE_MS_WIDTH > 24)
    begin : g_bad_params
        $error("fusa_top: unsupported parameter values");
    end

    localparam int MS_W = $clog2(MS_CYCLES + 1);

    typedef struct packed {
        fusa_mode_e mode;
        logic safe;
        logic [31:0] alarm_en;
        logic [31:0] warn_en;
        fusa_temp_e hi_st;
        fusa_temp_e lo_st;
        logic [SETTLE_MS_WIDTH-1:0] hi_ms;
        logic [SETTLE_MS_WIDTH-1:0] lo_ms;
        logic [MS_W-1:0] hi_sub;
        logic [MS_W-1:0] lo_sub;
        logic [31:0] err_w;
        logic [31:0] alm_w;
        logic [31:0] wrn_w;
        logic [31:0] st_w;
        logic [31:0] rdata;
    } fusa_state_s;

    fusa_state_s s_q;
    fusa_state_s s_d;

    // ----------------------------------------
    // Temperature persistence step
    // ----------------------------------------
    function automatic void temp_step(
        input fusa_temp_e st,
        input logic [SETTLE_MS_WIDTH-1:0] cnt,
        input logic [MS_W-1:0] sub,
        input logic beyond,
        input logic [SETTLE_MS_WIDTH-1:0] limit,
        output fusa_temp_e st_n,
        output logic [SETTLE_MS_WIDTH-1:0] cnt_n,
        output logic [MS_W-1:0] sub_n
    );
        st_n = st;
        cnt_n = '0;
        sub_n = '0;
        case (st)
            FUSA_T_NORMAL:
            begin
                if (beyond)
                    st_n = FUSA_T_PEND_SET;
            end
            FUSA_T_PEND_SET:
            begin
                if (!beyond)
                    st_n = FUSA_T_NORMAL;
                else if (cnt >= limit)
                    st_n = FUSA_T_TRIPPED;
            end
            FUSA_T_TRIPPED:
            begin
                if (!beyond)
                    st_n = FUSA_T_PEND_CLR;
            end
            default:
            begin
                if (beyond)
                    st_n = FUSA_T_TRIPPED;
                else if (cnt >= limit)
                    st_n = FUSA_T_NORMAL;
            end
        endcase
        // Own cycle count per pending state, no phase error against a shared tick
        if (st_n == st && (st == FUSA_T_PEND_SET || st == FUSA_T_PEND_CLR))
        begin
            if (sub == MS_W'(MS_CYCLES - 1))
                cnt_n = cnt + 1'b1;
            else
            begin
                cnt_n = cnt;
                sub_n = sub + 1'b1;
            end
        end
    endfunction : temp_step

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic [31:0] err_m, err_s, alm_m, alm_s, wrn_m, wrn_s;
    logic [5:1] stt_m, stt_s;
    logic conn_m, conn_s;

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            err_m <= '0;
            err_s <= '0;
            alm_m <= '0;
            alm_s <= '0;
            wrn_m <= '0;
            wrn_s <= '0;
            stt_m <= '0;
            stt_s <= '0;
            conn_m <= 1'b0;
            conn_s <= 1'b0;
        end
        else
        begin
            err_m <= error_sources;
            err_s <= err_m;
            alm_m <= alarm_sources;
            alm_s <= alm_m;
            wrn_m <= warning_sources;
            wrn_s <= wrn_m;
            stt_m <= state_sources;
            stt_s <= stt_m;
            conn_m <= class1_connected;
            conn_s <= conn_m;
        end
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        logic [31:0] err_raw;
        logic [31:0] alm_raw;
        logic [31:0] wrn_raw;
        logic [31:0] st_raw;
        fusa_temp_e hn;
        fusa_temp_e ln;
        logic [SETTLE_MS_WIDTH-1:0] hc;
        logic [SETTLE_MS_WIDTH-1:0] lc;
        logic [MS_W-1:0] hs;
        logic [MS_W-1:0] ls;
        err_raw = '0;
        alm_raw = '0;
        wrn_raw = '0;
        st_raw = '0;
        hn = s_q.hi_st;
        ln = s_q.lo_st;
        hc = s_q.hi_ms;
        lc = s_q.lo_ms;
        hs = s_q.hi_sub;
        ls = s_q.lo_sub;
        s_d = s_q;
        err_raw = err_s & ERROR_USED_MASK;
        if (|err_raw)
        begin
            s_d.mode = FUSA_SAFE;
            s_d.safe = 1'b1;
        end
        temp_step(s_q.hi_st, s_q.hi_ms, s_q.hi_sub, temperature > temp_high_trip, temp_settle_ms, hn, hc, hs);
        temp_step(s_q.lo_st, s_q.lo_ms, s_q.lo_sub, temperature < temp_low_trip, temp_settle_ms, ln, lc, ls);
        s_d.hi_st = hn;
        s_d.lo_st = ln;
        s_d.hi_ms = hc;
        s_d.lo_ms = lc;
        s_d.hi_sub = hs;
        s_d.lo_sub = ls;
        alm_raw = alm_s & s_q.alarm_en & ALARM_USED_MASK;
        wrn_raw = wrn_s;
        wrn_raw[WARN_HIGH_TEMP_BIT] = s_q.hi_st[1];
        wrn_raw[WARN_LOW_TEMP_BIT] = s_q.lo_st[1];
        wrn_raw = wrn_raw & s_q.warn_en & WARNING_USED_MASK;
        st_raw = '0;
        st_raw[5:1] = stt_s;
        st_raw[ST_EXEC_BIT] = (s_q.mode == FUSA_RUN) && !(|err_raw) && conn_s;
        st_raw[ST_ANY_ERROR_BIT] = |err_raw;
        st_raw[ST_ANY_ALARM_BIT] = |alm_raw;
        st_raw[ST_ANY_WARNING_BIT] = |wrn_raw;
        s_d.err_w = err_raw;
        s_d.alm_w = alm_raw;
        s_d.wrn_w = wrn_raw;
        s_d.st_w = st_raw & STATE_USED_MASK;
        if (reg_write)
        begin
            if (reg_index == ALARM_ENABLE_BITS_IDX)
                s_d.alarm_en = reg_wdata;
            else if (reg_index == WARNING_ENABLE_BITS_IDX)
                s_d.warn_en = reg_wdata;
        end
        if (reg_index == ERROR_STATUS_WORD_IDX)
            s_d.rdata = s_q.err_w;
        else if (reg_index == ALARM_STATUS_WORD_IDX)
            s_d.rdata = s_q.alm_w;
        else if (reg_index == WARNING_STATUS_WORD_IDX)
            s_d.rdata = s_q.wrn_w;
        else if (reg_index == UNIT_STATE_WORD_IDX)
            s_d.rdata = s_q.st_w;
        else if (reg_index == ALARM_ENABLE_BITS_IDX)
            s_d.rdata = s_q.alarm_en;
        else if (reg_index == WARNING_ENABLE_BITS_IDX)
            s_d.rdata = s_q.warn_en;
        else
            s_d.rdata = '0;
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            s_q <= '0;
            s_q.mode <= FUSA_RUN;
            s_q.alarm_en <= ALARM_ENABLE_RESET;
            s_q.warn_en <= WARNING_ENABLE_RESET;
            s_q.hi_st <= FUSA_T_NORMAL;
            s_q.lo_st <= FUSA_T_NORMAL;
        end
        else
            s_q <= s_d;
    end

    assign reg_rdata = s_q.rdata;
    assign safe_state = s_q.safe;
    assign cyclic_error_word = s_q.err_w;
    assign cyclic_alarm_word = s_q.alm_w;
    assign cyclic_warning_word = s_q.wrn_w;
    assign cyclic_state_word = s_q.st_w;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    safe_entry_a: assert property (|(err_s & ERROR_USED_MASK) |=> safe_state)
        else $error("error did not force safe state");
    safe_hold_a: assert property (safe_state |=> safe_state)
        else $error("safe state left without reset");
    exec_safe_a: assert property (safe_state |=> !cyclic_state_word[ST_EXEC_BIT])
        else $error("executing while safe");
    exec_conn_a: assert property (!conn_s |=> !cyclic_state_word[ST_EXEC_BIT])
        else $error("executing without connection");
    alarm_mask_a: assert property (##1 (cyclic_alarm_word & ~$past(s_q.alarm_en)) == 32'h0)
        else $error("masked alarm reported");
    error_raw_a: assert property (##1 cyclic_error_word == ($past(err_s) & ERROR_USED_MASK))
        else $error("error word altered");
    reserved_zero_a: assert property ((cyclic_warning_word & ~WARNING_USED_MASK) == 32'h0)
        else $error("reserved warning bit set");
    sum_alarm_a: assert property (cyclic_state_word[ST_ANY_ALARM_BIT] == $past(|(alm_s & s_q.alarm_en & ALARM_USED_MASK)))
        else $error("alarm summary wrong");
    sum_error_a: assert property (##1 cyclic_state_word[ST_ANY_ERROR_BIT] == |$past(err_s & ERROR_USED_MASK))
        else $error("error summary wrong");
    hi_settle_a: assert property ((s_q.hi_st == FUSA_T_NORMAL) ##1 (s_q.hi_st == FUSA_T_PEND_SET && temp_settle_ms != '0)
        |=> s_q.hi_st != FUSA_T_TRIPPED)
        else $error("high trip without settling");

    enter_safe_c: cover property ($rose(safe_state));
    high_temp_c: cover property ($rose(cyclic_warning_word[WARN_HIGH_TEMP_BIT]));
    low_temp_c: cover property ($rose(cyclic_warning_word[WARN_LOW_TEMP_BIT]));
    exec_c: cover property ($rose(cyclic_state_word[ST_EXEC_BIT]));

endmodule : fusa_top

//--- dv/fusa_host_model.sv
// Fieldbus host model: writes masks, reads status words, holds the cyclic link
`timescale 1ns/1ps

module fusa_host_model
    import fusa_pkg::*;
(
    input wire logic clock,
    output logic [3:0] reg_index,
    output logic reg_write,
    output logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    output logic class1_connected
);
    initial
    begin
        reg_index = 4'h0;
        reg_write = 1'b0;
        reg_wdata = 32'h0000_0000;
        class1_connected = 1'b1;
    end

    task automatic set_conn(input logic up);
        @(negedge clock);
        class1_connected = up;
    endtask : set_conn

    // mask write, data garbled once released
    task automatic write_reg(input logic [3:0] idx, input logic [31:0] data);
        @(negedge clock);
        reg_index = idx;
        reg_write = 1'b1;
        reg_wdata = data;
        @(negedge clock);
        reg_write = 1'b0;
        reg_wdata = ~data;
    endtask : write_reg

    // status word read, one cycle answer
    task automatic read_reg(input logic [3:0] idx, output logic [31:0] data);
        @(negedge clock);
        reg_index = idx;
        @(negedge clock);
        data = reg_rdata;
    endtask : read_reg
endmodule : fusa_host_model

//--- dv/flow_unit_status_aggregator_tb.sv
// Self-checking bench for the flow unit status aggregator
`timescale 1ns/1ps

module flow_unit_status_aggregator_tb
    import fusa_pkg::*;
;
    typedef struct {
        logic [31:0] al, am, ea, wa, wm, ew;
        logic [5:1] st;
    } fusa_row_s;

    logic clock, resetn, reg_write, class1_connected, safe_state;
    logic [3:0] reg_index;
    logic [31:0] reg_wdata, reg_rdata, error_sources, alarm_sources, warning_sources;
    logic [31:0] cyclic_error_word, cyclic_alarm_word, cyclic_warning_word, cyclic_state_word;
    logic [5:1] state_sources;
    logic signed [15:0] temperature, temp_high_trip, temp_low_trip;
    logic [15:0] temp_settle_ms;
    logic [31:0] rd, exp_state;
    int n_mismatch = 0;
    int checks_done = 0;
    fusa_row_s rows [5];

    fusa_top i_dut (.clock(clock), .resetn(resetn), .reg_index(reg_index), .reg_write(reg_write),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .error_sources(error_sources),
        .alarm_sources(alarm_sources), .warning_sources(warning_sources), .state_sources(state_sources),
        .class1_connected(class1_connected), .temperature(temperature), .temp_high_trip(temp_high_trip),
        .temp_low_trip(temp_low_trip), .temp_settle_ms(temp_settle_ms), .safe_state(safe_state),
        .cyclic_error_word(cyclic_error_word), .cyclic_alarm_word(cyclic_alarm_word),
        .cyclic_warning_word(cyclic_warning_word), .cyclic_state_word(cyclic_state_word));

    fusa_host_model i_host (.clock(clock), .reg_index(reg_index), .reg_write(reg_write),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .class1_connected(class1_connected));

    // ----------------------------------------
    // Clock, watchdog and helpers
    // ----------------------------------------
    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    initial
    begin
        repeat (90000) @(posedge clock);
        n_mismatch++;
        give_verdict();
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wait_cycles(input int n);
        repeat (n) @(negedge clock);
    endtask : wait_cycles

    task automatic give_verdict();
        $display("Comparisons %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        resetn = 1'b0;
        error_sources = 32'h0000_0000;
        alarm_sources = 32'h0000_0000;
        warning_sources = 32'h0000_0000;
        state_sources = 5'h00;
        temperature = 16'sd25;
        temp_high_trip = 16'sd100;
        temp_low_trip = -16'sd20;
        temp_settle_ms = 16'h0000;
        rows[0] = '{32'hffff_ffff, 32'hffff_ffff, 32'h0180_800f, 32'hffff_ffff, 32'hffff_ffff, 32'h0c0e_6f3b, 5'h1f};
        rows[1] = '{32'hffff_ffff, 32'h0000_000f, 32'h0000_000f, 32'hffff_ffff, 32'h0000_0000, 32'h0000_0000, 5'h00};
        rows[2] = '{32'h0080_0000, 32'h007f_ffff, 32'h0000_0000, 32'h0800_0000, 32'hf800_0000, 32'h0800_0000, 5'h15};
        rows[3] = '{32'h0000_0000, 32'hffff_ffff, 32'h0000_0000, 32'h0000_4000, 32'hfe7f_ffff, 32'h0000_4000, 5'h0a};
        rows[4] = '{32'hfe7f_7ff0, 32'hffff_ffff, 32'h0000_0000, 32'hf3f1_90c4, 32'hffff_ffff, 32'h0000_0000, 5'h00};
        wait_cycles(5);
        resetn = 1'b1;
        i_host.read_reg(ALARM_ENABLE_BITS_IDX, rd);
        check(rd, ALARM_ENABLE_RESET);
        i_host.read_reg(WARNING_ENABLE_BITS_IDX, rd);
        check(rd, WARNING_ENABLE_RESET);
        i_host.read_reg(4'h7, rd);
        check(rd, 32'h0000_0000);
        check(cyclic_state_word, 32'h0000_0001);
        for (int i = 0; i < 5; i++)
        begin
            @(negedge clock);
            alarm_sources = rows[i].al;
            warning_sources = rows[i].wa;
            state_sources = rows[i].st;
            i_host.write_reg(ALARM_ENABLE_BITS_IDX, rows[i].am);
            i_host.write_reg(WARNING_ENABLE_BITS_IDX, rows[i].wm);
            wait_cycles(5);
            check(cyclic_alarm_word, rows[i].ea);
            check(cyclic_warning_word, rows[i].ew);
            exp_state = {21'h0, |rows[i].ew, |rows[i].ea, 1'b0, 2'b00, rows[i].st, 1'b1};
            check(cyclic_state_word, exp_state);
            i_host.read_reg(ALARM_STATUS_WORD_IDX, rd);
            check(rd, rows[i].ea);
            i_host.read_reg(WARNING_STATUS_WORD_IDX, rd);
            check(rd, rows[i].ew);
        end
        alarm_sources = 32'h0000_0001;
        i_host.write_reg(ALARM_STATUS_WORD_IDX, 32'h0000_0000);
        i_host.write_reg(UNIT_STATE_WORD_IDX, 32'hffff_ffff);
        wait_cycles(5);
        check(cyclic_alarm_word, 32'h0000_0001);
        i_host.set_conn(1'b0);
        wait_cycles(5);
        check(cyclic_state_word, 32'h0000_0200);
        i_host.set_conn(1'b1);
        temperature = 16'sd101;
        wait_cycles(6);
        check(cyclic_warning_word, 32'h0100_0000);
        check(cyclic_state_word, 32'h0000_0601);
        i_host.write_reg(WARNING_ENABLE_BITS_IDX, 32'hfeff_ffff);
        wait_cycles(3);
        check(cyclic_warning_word, 32'h0000_0000);
        i_host.write_reg(WARNING_ENABLE_BITS_IDX, 32'hffff_ffff);
        temperature = -16'sd21;
        wait_cycles(6);
        check(cyclic_warning_word, 32'h0200_0000);
        temperature = -16'sd20;
        wait_cycles(6);
        check(cyclic_warning_word, 32'h0000_0000);
        temp_settle_ms = 16'h0001;
        temperature = 16'sd101;
        wait_cycles(30000);
        check(cyclic_warning_word, 32'h0000_0000);
        wait_cycles(10100);
        check(cyclic_warning_word, 32'h0100_0000);
        temperature = 16'sd25;
        wait_cycles(30000);
        check(cyclic_warning_word, 32'h0100_0000);
        wait_cycles(10100);
        check(cyclic_warning_word, 32'h0000_0000);
        error_sources = 32'hff7b_fffb;
        wait_cycles(5);
        check(cyclic_error_word, 32'h0000_0000);
        check({31'h0, safe_state}, 32'h0000_0000);
        error_sources = 32'h0084_0004;
        wait_cycles(5);
        check({31'h0, safe_state}, 32'h0000_0001);
        check(cyclic_state_word, 32'h0000_0300);
        check(cyclic_error_word, 32'h0084_0004);
        i_host.read_reg(ERROR_STATUS_WORD_IDX, rd);
        check(rd, 32'h0084_0004);
        error_sources = 32'h0000_0000;
        wait_cycles(20);
        check({31'h0, safe_state}, 32'h0000_0001);
        i_host.read_reg(UNIT_STATE_WORD_IDX, rd);
        check(rd, 32'h0000_0200);
        i_host.write_reg(ALARM_ENABLE_BITS_IDX, 32'h0000_0000);
        @(negedge clock);
        resetn = 1'b0;
        wait_cycles(2);
        resetn = 1'b1;
        wait_cycles(5);
        check({31'h0, safe_state}, 32'h0000_0000);
        check(cyclic_state_word, 32'h0000_0201);
        give_verdict();
    end
endmodule : flow_unit_status_aggregator_tb
